/* File: rtl/scpk_pkg.sv */
// shared constants and types for the serial command packet link
package scpk_pkg;
  // framing characters
  localparam logic [7:0] CH_ESC = 8'h1b;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_LBR = 8'h5b;
  localparam logic [7:0] CH_NUL = 8'h00;
  localparam logic [7:0] CH_ACK = 8'h06;
  localparam logic [7:0] CH_NAK = 8'h15;
  localparam logic [7:0] CH_Z = 8'h5a;
  localparam logic [7:0] CH_2 = 8'h32;
  // built-in command identifiers, right aligned ascii
  localparam logic [23:0] save_active_to_startup_cmd = 24'h00_5a32;
  localparam logic [23:0] uart_restore_defaults_cmd = 24'h00_5532;
  localparam logic [23:0] usbhid_restore_defaults_cmd = 24'h00_5355;
  localparam logic [23:0] usbcom_restore_defaults_cmd = 24'h43_3031;
  localparam logic [23:0] load_custom_settings_cmd = 24'h42_4150;
  localparam logic [23:0] store_custom_settings_cmd = 24'h42_4151;
  // limits
  localparam int MAX_LEN = 1000;
  localparam int LONG_PKT = 32;
  localparam int SAVE_LIMIT = 30000;
  localparam int COMM_W = 8;
  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int GAP_MS = 10;
  localparam int GAP_CYC = GAP_MS * (CLK_HZ / 1000);
  // host register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TX = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RX = 8'h0c;
  localparam logic [7:0] REG_COUNT = 8'h10;
  localparam logic [7:0] REG_SAVES = 8'h14;
  // ctrl fields
  localparam int CTRL_STX = 0;
  localparam int CTRL_RTS = 1;
  localparam int CTRL_ACK = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // tx word fields
  localparam int TX_START = 8;
  localparam int TX_END = 9;
  localparam int TX_LONG = 10;
  // status fields
  localparam int ST_BUSY = 0;
  localparam int ST_OVF = 1;
  localparam int ST_NAK = 2;
  localparam int ST_ACK = 3;
  localparam int ST_SAVE = 4;
  localparam int ST_PEND = 5;
  localparam int ST_RTS = 6;
  // device states
  typedef enum logic [2:0] {
    D_BOOT = 3'b000,
    D_IDLE = 3'b001,
    D_BODY = 3'b011,
    D_EXEC = 3'b010,
    D_WAIT = 3'b110,
    D_ACK = 3'b111
  } scpk_dstate_t;
  // host states
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_PACE = 3'b001,
    H_NUL = 3'b011,
    H_GAP = 3'b010,
    H_HDR = 3'b110,
    H_DATA = 3'b111,
    H_TERM = 3'b101,
    H_DONE = 3'b100
  } scpk_hstate_t;
endpackage

/* File: rtl/scpk_link_if.sv */
// byte link between host controller and command device
interface scpk_link_if;
  logic h2d_valid; // one-cycle byte strobe host to device
  logic [7:0] h2d_data; // byte host to device
  logic d2h_valid; // one-cycle ack/nak strobe
  logic [7:0] d2h_data; // ack or nak byte
  logic rts_busy; // device busy level
  modport dev (input h2d_valid, input h2d_data,
               output d2h_valid, output d2h_data, output rts_busy);
  modport host (output h2d_valid, output h2d_data,
                input d2h_valid, input d2h_data, input rts_busy);
endinterface

/* File: rtl/scpk_device.sv */
// command packet interpreter with settings areas
// Function
// - packet framed by escape and carriage return
// - ids: one-two chars, or bracket plus three
// - many ids per packet; single char alone
// - start/end of text also frames packet
// - host precedes long standby packets with null
// - payload over 1000 characters is dropped
// - host waits until previous command completes
// - request-to-send busy while command executes
// - ack sent after packet processed
// - command settings volatile until save command
// - comm settings applied only when saved
// - menu label settings stored immediately
// - device runs from volatile active settings
// - power-on copies startup area to active
// - load custom copies custom to active
// - store custom copies active to custom
// - uart default loads factory settings
// - three interface restore-default commands
// - host flags a status bit once 30000 saves are sent
module scpk_device #(
  parameter int SET_W = 16,
  parameter logic [SET_W-1:0] STARTUP_INIT = '0,
  parameter logic [SET_W-1:0] FACT_UART = '0,
  parameter logic [SET_W-1:0] FACT_COM = '0,
  parameter logic [SET_W-1:0] FACT_HID = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  scpk_link_if.dev link,
  input wire logic ack_en,
  input wire logic hs_en,
  input wire logic menu_valid,
  input wire logic [SET_W-1:0] menu_mask,
  input wire logic [SET_W-1:0] menu_data,
  input wire logic set_valid,
  input wire logic [SET_W-1:0] set_data,
  input wire logic cmd_done,
  output logic cmd_valid,
  output logic [23:0] cmd_id,
  output logic [SET_W-1:0] active,
  output logic [SET_W-1:0] startup_area,
  output logic [SET_W-1:0] custom_area,
  output logic [scpk_pkg::COMM_W-1:0] comm_applied,
  output logic [15:0] nvm_writes,
  output logic pkt_error
);
  scpk_pkg::scpk_dstate_t state, next_state; // parser state
  logic [7:0] term; // expected terminator
  logic brk; // bracket seen for current id
  logic [1:0] nchar; // chars of current id
  logic [23:0] idb; // id being collected
  logic [10:0] len; // payload length
  logic ovf; // length limit passed
  logic had_id; // an id already run in this packet
  logic last; // running id closes the packet
  logic rx; // byte arrives
  logic hdr; // byte is a header
  logic is_term; // byte is the terminator
  logic one_char; // lone single-char id at terminator
  logic id_full; // byte completes an id
  logic builtin; // id handled internally
  logic [SET_W-1:0] menu_val; // active merged with menu label

  // byte classification
  always_comb begin
    rx = link.h2d_valid;
    hdr = rx && (link.h2d_data == scpk_pkg::CH_ESC ||
                 link.h2d_data == scpk_pkg::CH_STX);
    is_term = rx && link.h2d_data == term;
    one_char = nchar == 2'd1 && !brk && !had_id && !ovf;
    id_full = brk ? nchar == 2'd2 : nchar == 2'd1;
    builtin = idb == scpk_pkg::save_active_to_startup_cmd ||
              idb == scpk_pkg::uart_restore_defaults_cmd ||
              idb == scpk_pkg::usbcom_restore_defaults_cmd ||
              idb == scpk_pkg::usbhid_restore_defaults_cmd ||
              idb == scpk_pkg::load_custom_settings_cmd ||
              idb == scpk_pkg::store_custom_settings_cmd;
    menu_val = (active & ~menu_mask) | (menu_data & menu_mask);
  end

  // next parser state
  always_comb begin
    next_state = state;
    case (state)
      scpk_pkg::D_BOOT: next_state = scpk_pkg::D_IDLE;
      scpk_pkg::D_IDLE: begin
        if (hdr) begin
          next_state = scpk_pkg::D_BODY;
        end
      end
      scpk_pkg::D_BODY: begin
        if (is_term) begin
          next_state = one_char ? scpk_pkg::D_EXEC : scpk_pkg::D_ACK;
        end else if (rx && !hdr && !ovf && len < 11'(scpk_pkg::MAX_LEN)
                     && !(nchar == 2'd0 && !brk &&
                          link.h2d_data == scpk_pkg::CH_LBR)
                     && id_full) begin
          next_state = scpk_pkg::D_EXEC;
        end
      end
      scpk_pkg::D_EXEC: begin
        if (!builtin) begin
          next_state = scpk_pkg::D_WAIT;
        end else begin
          next_state = last ? scpk_pkg::D_ACK : scpk_pkg::D_BODY;
        end
      end
      scpk_pkg::D_WAIT: begin
        if (cmd_done) begin
          next_state = last ? scpk_pkg::D_ACK : scpk_pkg::D_BODY;
        end
      end
      scpk_pkg::D_ACK: next_state = scpk_pkg::D_IDLE;
      default: next_state = scpk_pkg::D_IDLE;
    endcase
  end

  // state register and busy line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= scpk_pkg::D_BOOT;
      link.rts_busy <= 1'b0;
    end else begin
      state <= next_state;
      // busy while executing, bytes dropped meanwhile
      link.rts_busy <= hs_en && (next_state == scpk_pkg::D_EXEC ||
                                 next_state == scpk_pkg::D_WAIT ||
                                 next_state == scpk_pkg::D_BOOT);
    end
  end

  // packet tracking: terminator, id assembly, length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term <= scpk_pkg::CH_CR;
      brk <= 1'b0;
      nchar <= 2'd0;
      idb <= 24'h00_0000;
      len <= 11'h000;
      ovf <= 1'b0;
      had_id <= 1'b0;
      last <= 1'b0;
      pkt_error <= 1'b0;
    end else if (hdr && (state == scpk_pkg::D_IDLE ||
                         state == scpk_pkg::D_BODY)) begin
      term <= link.h2d_data == scpk_pkg::CH_ESC ? scpk_pkg::CH_CR
                                                : scpk_pkg::CH_ETX;
      brk <= 1'b0;
      nchar <= 2'd0;
      len <= 11'h000;
      ovf <= 1'b0;
      had_id <= 1'b0;
      last <= 1'b0;
      pkt_error <= 1'b0;
    end else if (state == scpk_pkg::D_BODY && is_term) begin
      last <= 1'b1;
      // leftover or non-alone single char is an error
      pkt_error <= ovf || brk || (nchar != 2'd0 && !one_char);
      nchar <= 2'd0;
      brk <= 1'b0;
    end else if (state == scpk_pkg::D_BODY && rx) begin
      if (len >= 11'(scpk_pkg::MAX_LEN)) begin
        ovf <= 1'b1;
      end else begin
        len <= len + 11'd1;
        if (nchar == 2'd0 && !brk && link.h2d_data == scpk_pkg::CH_LBR)
        begin
          brk <= 1'b1;
        end else if (id_full) begin
          idb <= nchar == 2'd0 ? {16'h0000, link.h2d_data}
                               : {idb[15:0], link.h2d_data};
          nchar <= 2'd0;
          brk <= 1'b0;
          had_id <= 1'b1;
        end else begin
          idb <= nchar == 2'd0 ? {16'h0000, link.h2d_data}
                               : {idb[15:0], link.h2d_data};
          nchar <= nchar + 2'd1;
        end
      end
    end
  end

  // handoff of non-built-in ids to the application
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_valid <= 1'b0;
      cmd_id <= 24'h00_0000;
    end else begin
      cmd_valid <= state == scpk_pkg::D_EXEC && !builtin;
      if (state == scpk_pkg::D_EXEC) begin
        cmd_id <= idb;
      end
    end
  end

  // acknowledge at packet end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.d2h_valid <= 1'b0;
      link.d2h_data <= scpk_pkg::CH_ACK;
    end else begin
      // ack after processing, nak on error
      link.d2h_valid <= state == scpk_pkg::D_ACK && ack_en;
      if (state == scpk_pkg::D_ACK) begin
        link.d2h_data <= pkt_error ? scpk_pkg::CH_NAK : scpk_pkg::CH_ACK;
      end
    end
  end

  // settings areas, menu label beats everything but the power-on copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active <= '0;
      startup_area <= STARTUP_INIT;
      custom_area <= '0;
      comm_applied <= '0;
      nvm_writes <= 16'h0000;
    end else if (state == scpk_pkg::D_BOOT) begin
      active <= startup_area;
      comm_applied <= startup_area[scpk_pkg::COMM_W-1:0];
    end else if (menu_valid) begin
      // menu setting stored with pending changes
      active <= menu_val;
      startup_area <= menu_val;
      comm_applied <= menu_val[scpk_pkg::COMM_W-1:0];
      nvm_writes <= nvm_writes + 16'd1;
    end else if (state == scpk_pkg::D_EXEC && builtin) begin
      case (idb)
        scpk_pkg::save_active_to_startup_cmd: begin
          startup_area <= active;
          comm_applied <= active[scpk_pkg::COMM_W-1:0];
          nvm_writes <= nvm_writes + 16'd1;
        end
        scpk_pkg::uart_restore_defaults_cmd: active <= FACT_UART;
        scpk_pkg::usbcom_restore_defaults_cmd: active <= FACT_COM;
        scpk_pkg::usbhid_restore_defaults_cmd: active <= FACT_HID;
        scpk_pkg::load_custom_settings_cmd: active <= custom_area;
        scpk_pkg::store_custom_settings_cmd: begin
          custom_area <= active;
          nvm_writes <= nvm_writes + 16'd1;
        end
        default: active <= active;
      endcase
    end else if (set_valid) begin
      active <= set_data;
    end
  end
endmodule

/* File: rtl/scpk_host.sv */
// host controller sending command packets, apb register port
module scpk_host #(
  parameter int GAP_CYCLES = scpk_pkg::GAP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  scpk_link_if.host link
);
  scpk_pkg::scpk_hstate_t state; // sequencer state
  logic [2:0] ctrl; // framing and pacing options
  logic [10:0] jb; // latched tx word
  logic [10:0] count; // payload characters this packet
  logic [19:0] gap; // null-to-header wait
  logic [15:0] saves; // save commands sent
  logic [7:0] last_rx; // last ack byte
  logic ovf, nak, ack_seen, ack_pend, prev_z; // status flags
  logic setup; // apb setup cycle
  logic done; // apb completion edge
  logic tx_go; // tx write starts a job
  logic [31:0] status; // status view

  // apb phase decode
  always_comb begin
    setup = psel && !penable;
    done = psel && penable && pready;
    tx_go = setup && pwrite && paddr == scpk_pkg::REG_TX;
    status = 32'h0000_0000;
    status[scpk_pkg::ST_BUSY] = state != scpk_pkg::H_IDLE;
    status[scpk_pkg::ST_OVF] = ovf;
    status[scpk_pkg::ST_NAK] = nak;
    status[scpk_pkg::ST_ACK] = ack_seen;
    status[scpk_pkg::ST_SAVE] = saves >= 16'(scpk_pkg::SAVE_LIMIT);
    status[scpk_pkg::ST_PEND] = ack_pend;
    status[scpk_pkg::ST_RTS] = link.rts_busy;
  end

  // apb answer: no wait state, tx waits for its job
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      pready <= !tx_go;
      pslverr <= !(paddr == scpk_pkg::REG_CTRL || paddr == scpk_pkg::REG_TX
                   || paddr == scpk_pkg::REG_STATUS ||
                   paddr == scpk_pkg::REG_RX ||
                   paddr == scpk_pkg::REG_COUNT ||
                   paddr == scpk_pkg::REG_SAVES);
      case (paddr)
        scpk_pkg::REG_CTRL: prdata <= {29'h0, ctrl};
        scpk_pkg::REG_STATUS: prdata <= status;
        scpk_pkg::REG_RX: prdata <= {24'h00_0000, last_rx};
        scpk_pkg::REG_COUNT: prdata <= {21'h00_0000, count};
        scpk_pkg::REG_SAVES: prdata <= {16'h0000, saves};
        default: prdata <= 32'h0000_0000;
      endcase
    end else if (state == scpk_pkg::H_DONE) begin
      pready <= 1'b1;
    end else if (done) begin
      pready <= 1'b0;
    end
  end

  // ctrl register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= scpk_pkg::CTRL_RST;
    end else if (done && pwrite && paddr == scpk_pkg::REG_CTRL) begin
      ctrl <= pwdata[2:0];
    end
  end

  // packet sequencer and link drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= scpk_pkg::H_IDLE;
      jb <= 11'h000;
      count <= 11'h000;
      gap <= 20'h0_0000;
      saves <= 16'h0000;
      prev_z <= 1'b0;
      ovf <= 1'b0;
      link.h2d_valid <= 1'b0;
      link.h2d_data <= scpk_pkg::CH_NUL;
    end else begin
      link.h2d_valid <= 1'b0;
      if (done && pwrite && paddr == scpk_pkg::REG_STATUS &&
          pwdata[scpk_pkg::ST_OVF]) begin
        ovf <= 1'b0;
      end
      case (state)
        scpk_pkg::H_IDLE: begin
          if (tx_go) begin
            jb <= pwdata[10:0];
            state <= scpk_pkg::H_PACE;
          end
        end
        scpk_pkg::H_PACE: begin
          // wait for busy line and for pending ack
          if (!(ctrl[scpk_pkg::CTRL_RTS] && link.rts_busy) &&
              !(jb[scpk_pkg::TX_START] && ctrl[scpk_pkg::CTRL_ACK] &&
                ack_pend)) begin
            if (!jb[scpk_pkg::TX_START]) begin
              state <= scpk_pkg::H_DATA;
            end else if (jb[scpk_pkg::TX_LONG]) begin
              state <= scpk_pkg::H_NUL;
            end else begin
              state <= scpk_pkg::H_HDR;
            end
          end
        end
        scpk_pkg::H_NUL: begin
          link.h2d_valid <= 1'b1;
          link.h2d_data <= scpk_pkg::CH_NUL;
          gap <= 20'h0_0000;
          state <= scpk_pkg::H_GAP;
        end
        scpk_pkg::H_GAP: begin
          gap <= gap + 20'd1;
          if (gap >= 20'(GAP_CYCLES - 1)) begin
            state <= scpk_pkg::H_HDR;
          end
        end
        scpk_pkg::H_HDR: begin
          link.h2d_valid <= 1'b1;
          link.h2d_data <= ctrl[scpk_pkg::CTRL_STX] ? scpk_pkg::CH_STX
                                                    : scpk_pkg::CH_ESC;
          count <= 11'h000;
          prev_z <= 1'b0;
          state <= scpk_pkg::H_DATA;
        end
        scpk_pkg::H_DATA: begin
          if (count < 11'(scpk_pkg::MAX_LEN)) begin
            link.h2d_valid <= 1'b1;
            link.h2d_data <= jb[7:0];
            count <= count + 11'd1;
            prev_z <= jb[7:0] == scpk_pkg::CH_Z;
            if (prev_z && jb[7:0] == scpk_pkg::CH_2 && saves != 16'hffff)
            begin
              saves <= saves + 16'd1;
            end
          end else begin
            ovf <= 1'b1;
          end
          // terminator starts with one settling cycle
          gap <= 20'h0_0000;
          state <= jb[scpk_pkg::TX_END] ? scpk_pkg::H_TERM
                                        : scpk_pkg::H_DONE;
        end
        scpk_pkg::H_TERM: begin
          // let busy rise, then hold terminator while busy
          if (gap == 20'h0_0000) begin
            gap <= 20'h0_0001;
          end else if (!(ctrl[scpk_pkg::CTRL_RTS] && link.rts_busy)) begin
            link.h2d_valid <= 1'b1;
            link.h2d_data <= ctrl[scpk_pkg::CTRL_STX] ? scpk_pkg::CH_ETX
                                                      : scpk_pkg::CH_CR;
            state <= scpk_pkg::H_DONE;
          end
        end
        scpk_pkg::H_DONE: state <= scpk_pkg::H_IDLE;
        default: state <= scpk_pkg::H_IDLE;
      endcase
    end
  end

  // ack tracking; a set beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_rx <= 8'h00;
      nak <= 1'b0;
      ack_seen <= 1'b0;
      ack_pend <= 1'b0;
    end else begin
      if (done && pwrite && paddr == scpk_pkg::REG_STATUS) begin
        if (pwdata[scpk_pkg::ST_NAK]) begin
          nak <= 1'b0;
        end
        if (pwdata[scpk_pkg::ST_ACK]) begin
          ack_seen <= 1'b0;
        end
      end
      if (state == scpk_pkg::H_TERM && ctrl[scpk_pkg::CTRL_ACK]) begin
        ack_pend <= 1'b1;
      end else if (link.d2h_valid) begin
        ack_pend <= 1'b0;
      end
      if (link.d2h_valid) begin
        last_rx <= link.d2h_data;
        if (link.d2h_data == scpk_pkg::CH_NAK) begin
          nak <= 1'b1;
        end else begin
          ack_seen <= 1'b1;
        end
      end
    end
  end
endmodule

/* File: test/scpk_link_checker.sv */
// link protocol assertions for the command packet link
module scpk_link_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic h2d_valid,
  input wire logic [7:0] h2d_data,
  input wire logic d2h_valid,
  input wire logic [7:0] d2h_data,
  input wire logic rts_busy,
  input wire logic hs_en,
  input wire logic ack_en
);
  // one clock domain, one reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ack_pulse;
    d2h_valid |=> !d2h_valid;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("answer strobe longer than one cycle");
  property p_ack_code;
    d2h_valid |-> (d2h_data == 8'h06 || d2h_data == 8'h15);
  endproperty
  a_ack_code: assert property (p_ack_code)
    else $error("answer byte is neither ack nor nak");
  property p_byte_pulse;
    h2d_valid && h2d_data != 8'h1b && h2d_data != 8'h02 |=> !h2d_valid;
  endproperty
  a_byte_pulse: assert property (p_byte_pulse)
    else $error("byte sent right after a payload byte");
  property p_rts_gated;
    !$past(hs_en) |-> !rts_busy;
  endproperty
  a_rts_gated: assert property (p_rts_gated)
    else $error("busy driven without handshake");
  property p_rts_ends;
    rts_busy |-> ##[0:300] !rts_busy;
  endproperty
  a_rts_ends: assert property (p_rts_ends)
    else $error("busy never released");
  property p_term_ack;
    h2d_valid && ack_en && (h2d_data == 8'h0d || h2d_data == 8'h03)
      |-> ##[1:300] d2h_valid;
  endproperty
  a_term_ack: assert property (p_term_ack)
    else $error("no answer after terminator");
  property p_ack_idle;
    d2h_valid |-> !rts_busy;
  endproperty
  a_ack_idle: assert property (p_ack_idle)
    else $error("answer sent while still busy");
  property p_ack_enabled;
    d2h_valid |-> $past(ack_en);
  endproperty
  a_ack_enabled: assert property (p_ack_enabled)
    else $error("answer sent while disabled");
endmodule

/* File: test/serial_command_packet_settings_tb.sv */
// self-checking bench: host and device joined over the link
module serial_command_packet_settings_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] ST0 = 16'h1234; // startup area at power-on
  localparam logic [15:0] FU = 16'h0a0b; // uart factory set
  localparam logic [15:0] FC = 16'h0c0d; // usb serial factory set
  localparam logic [15:0] FH = 16'h0e0f; // usb keyboard factory set
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ack_en, hs_en, menu_valid, set_valid, cmd_done, cmd_valid;
  logic pkt_error, er;
  logic [15:0] menu_mask, menu_data, set_data, active;
  logic [15:0] startup_area, custom_area, nvm_writes;
  logic [7:0] comm_applied;
  logic [23:0] cmd_id, last_cmd;
  int num_errors = 0;
  int check_count = 0;
  int ack_cnt = 0;
  int nul_cnt = 0; // null bytes seen on the link
  localparam int GAP_NS = 20 * 50; // null-to-header wait, 20 cycles
  logic long_first = 1'b0; // first byte asks for null and gap
  time t0; // start of a timed packet
  scpk_link_if link();
  scpk_host #(.GAP_CYCLES(20)) scpk_host_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  scpk_device #(.SET_W(16), .STARTUP_INIT(ST0), .FACT_UART(FU),
    .FACT_COM(FC), .FACT_HID(FH)) scpk_device_inst (.pclk(pclk),
    .presetn(presetn), .link(link), .ack_en(ack_en), .hs_en(hs_en),
    .menu_valid(menu_valid), .menu_mask(menu_mask),
    .menu_data(menu_data), .set_valid(set_valid), .set_data(set_data),
    .cmd_done(cmd_done), .cmd_valid(cmd_valid), .cmd_id(cmd_id),
    .active(active), .startup_area(startup_area),
    .custom_area(custom_area), .comm_applied(comm_applied),
    .nvm_writes(nvm_writes), .pkt_error(pkt_error));
  scpk_link_checker scpk_link_checker_inst (.pclk(pclk),
    .presetn(presetn), .h2d_valid(link.h2d_valid),
    .h2d_data(link.h2d_data), .d2h_valid(link.d2h_valid),
    .d2h_data(link.d2h_data), .rts_busy(link.rts_busy), .hs_en(hs_en),
    .ack_en(ack_en));
  // clock, 50 ns period
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // application side: finish commands a cycle later, log answers
  always @(posedge pclk) begin
    if (presetn !== 1'b1) begin
      cmd_done <= 1'b0;
      last_cmd <= 24'h00_0000;
    end else begin
      cmd_done <= cmd_valid;
      if (cmd_valid === 1'b1) last_cmd <= cmd_id;
      if (link.d2h_valid === 1'b1) ack_cnt <= ack_cnt + 1;
      if (link.h2d_valid === 1'b1 && link.h2d_data === 8'h00) begin
        nul_cnt <= nul_cnt + 1;
      end
    end
  end
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, entered right after a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 2000);
    if (pready !== 1'b1) chk(32'(pready), 32'h0000_0001);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one framed packet of nb bytes, then wait for its answer
  task automatic send(input logic [47:0] ids, input int nb);
    logic [31:0] w;
    int a0, n;
    a0 = ack_cnt;
    n = 0;
    for (int i = 0; i < nb; i++) begin
      w = {21'h0, 1'(i == 0 && long_first), 1'(i == nb - 1), 1'(i == 0),
           ids[8*(nb-1-i) +: 8]};
      apb(1'b1, scpk_pkg::REG_TX, w, rd, er);
    end
    while (ack_cnt == a0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(ack_cnt - a0), 32'h0000_0001);
    repeat (2) @(posedge pclk);
  endtask
  // closing report
  task automatic print_verdict();
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // watchdog against hangs
  initial begin
    #1000000;
    num_errors++;
    print_verdict();
  end
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {menu_valid, menu_mask, menu_data, set_valid, set_data} = '0;
    ack_en = 1'b1;
    hs_en = 1'b1;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(active, ST0);
    chk(startup_area, ST0);
    apb(1'b1, scpk_pkg::REG_CTRL, 32'h0000_0006, rd, er);
    send({32'h0, scpk_pkg::uart_restore_defaults_cmd[15:0]}, 2);
    chk(active, FU);
    chk(pkt_error, 1'b0);
    send({16'h0, scpk_pkg::CH_LBR, scpk_pkg::usbcom_restore_defaults_cmd}, 4);
    chk(active, FC);
    send({32'h0, scpk_pkg::usbhid_restore_defaults_cmd[15:0]}, 2);
    chk(active, FH);
    chk(comm_applied, ST0[7:0]);
    chk(startup_area, ST0);
    apb(1'b1, scpk_pkg::REG_CTRL, 32'h0000_0007, rd, er);
    set_valid <= 1'b1;
    set_data <= 16'ha5c3;
    @(posedge pclk);
    set_valid <= 1'b0;
    send({16'h0, scpk_pkg::CH_LBR, scpk_pkg::store_custom_settings_cmd}, 4);
    chk(custom_area, 16'ha5c3);
    send({32'h0, scpk_pkg::uart_restore_defaults_cmd[15:0]}, 2);
    chk(active, FU);
    send({scpk_pkg::CH_LBR, scpk_pkg::load_custom_settings_cmd,
      scpk_pkg::save_active_to_startup_cmd[15:0]}, 6);
    chk(active, 16'ha5c3);
    chk(startup_area, 16'ha5c3);
    chk(comm_applied, 8'hc3);
    chk(nvm_writes, 16'h0002);
    long_first = 1'b1;
    t0 = $time;
    send({40'h0, 8'h58}, 1);
    long_first = 1'b0;
    chk(last_cmd, 24'h00_0058);
    chk(32'(nul_cnt), 32'h0000_0001);
    chk(32'($time - t0 > GAP_NS), 32'h0000_0001);
    send({24'h0, scpk_pkg::CH_LBR, 16'h4142}, 3);
    chk(pkt_error, 1'b1);
    apb(1'b0, scpk_pkg::REG_RX, 32'h0000_0000, rd, er);
    chk(rd, 32'h0000_0015);
    apb(1'b0, scpk_pkg::REG_SAVES, 32'h0000_0000, rd, er);
    chk(rd, 32'h0000_0001);
    hs_en <= 1'b0;
    menu_valid <= 1'b1;
    menu_mask <= 16'h00ff;
    menu_data <= 16'h0055;
    @(posedge pclk);
    menu_valid <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(active, 16'ha555);
    chk(startup_area, 16'ha555);
    chk(nvm_writes, 16'h0003);
    hs_en <= 1'b1;
    apb(1'b0, scpk_pkg::REG_CTRL, 32'h0000_0000, rd, er);
    chk(rd, 32'h0000_0007);
    apb(1'b1, 8'h40, 32'h0000_0001, rd, er);
    chk(32'(er), 32'h0000_0001);
    print_verdict();
  end
endmodule
